//--- inc/ufcm_pkg.sv
package ufcm_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BAUD_RATE = 115_200;
  localparam logic [15:0] BIT_CYCLES = 16'(CLK_HZ / BAUD_RATE);
  localparam logic [15:0] HALF_BIT_CYCLES = 16'(CLK_HZ / BAUD_RATE / 2);
  // ****************************************
  // Register indices, byte address is four times the index
  // ****************************************
  localparam logic [3:0] IDX_MODE_ONE = 4'h0;
  localparam logic [3:0] IDX_MODE_TWO = 4'h1;
  localparam logic [3:0] IDX_STATUS = 4'h2;
  localparam logic [3:0] IDX_DATA = 4'h3;
  localparam logic [3:0] IDX_CONTROL = 4'h4;
  localparam logic [3:0] IDX_INPUT_CHANGE = 4'h5;
  localparam logic [3:0] IDX_INT_STATUS = 4'h6;
  localparam logic [3:0] IDX_INT_MASK = 4'h7;
  localparam logic [3:0] IDX_OUTPUT_PORT = 4'h8;
  localparam logic [3:0] IDX_SET_OUTPUT = 4'hE;
  localparam logic [3:0] IDX_CLEAR_OUTPUT = 4'hF;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned MR1_RX_RTS = 7;
  localparam int unsigned MR1_PAR_SEL = 2;
  localparam int unsigned MR2_TX_RTS = 5;
  localparam int unsigned MR2_CTS_EN = 4;
  localparam int unsigned MR2_STOP_TWO = 3;
  localparam int unsigned CTL_RX_EN = 0;
  localparam int unsigned CTL_TX_EN = 1;
  localparam int unsigned RTS_PIN = 0;
  localparam logic [1:0] PAR_FORCE = 2'h1;
  localparam logic [1:0] PAR_NONE = 2'h2;
  localparam logic [1:0] PAR_MULTIDROP = 2'h3;
  localparam logic [1:0] FIFO_DEPTH = 2'h3;
  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [1:0] lenCode;
    logic hasExtra;
    logic stopTwo;
  } ufcm_frame_t;
  typedef struct packed {
    logic [7:0] data;
    logic extra;
    logic frameErr;
  } ufcm_rxchar_t;
  function automatic logic parityOf(input logic [7:0] d, input logic [1:0] lenCode,
                                    input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 8; i++) begin
      if (i < 5 + int'(lenCode)) begin
        p = p ^ d[i];
      end
    end
    return p;
  endfunction : parityOf
endpackage : ufcm_pkg

//--- logic/ufcm_tx.sv
`timescale 1ns/1ps
module ufcm_tx (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire ufcm_pkg::ufcm_frame_t frame,
  input wire logic [7:0] word,
  input wire logic extra,
  output logic busy,
  output logic txd
);
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} ufcm_txstate_t;
  ufcm_txstate_t state, next_state;
  logic [11:0] shifter, next_shifter;
  logic [3:0] bitsLeft, next_bitsLeft;
  logic [15:0] divCnt, next_divCnt;
  logic next_txd;

  always_comb begin
    logic [11:0] f;
    f = '1;
    next_state = state;
    next_shifter = shifter;
    next_bitsLeft = bitsLeft;
    next_divCnt = divCnt;
    next_txd = txd;
    case (state)
      TX_IDLE: begin
        next_txd = 1'b1;
        if (start) begin
          f[0] = 1'b0;
          for (int i = 0; i < 8; i++) begin
            if (i < 5 + int'(frame.lenCode)) begin
              f[i + 1] = word[i];
            end
          end
          // Flag or parity bit sits right after the data bits
          if (frame.hasExtra) begin
            f[6 + int'(frame.lenCode)] = extra;
          end
          next_txd = f[0];
          next_shifter = f >> 1;
          next_bitsLeft = 4'd6 + 4'(frame.lenCode) + 4'(frame.hasExtra) + 4'(frame.stopTwo);
          next_divCnt = ufcm_pkg::BIT_CYCLES - 16'h0001;
          next_state = TX_SEND;
        end
      end
      TX_SEND: begin
        if (divCnt == 16'h0000) begin
          if (bitsLeft == 4'h0) begin
            next_txd = 1'b1;
            next_state = TX_IDLE;
          end else begin
            next_txd = shifter[0];
            next_shifter = shifter >> 1;
            next_bitsLeft = bitsLeft - 4'h1;
            next_divCnt = ufcm_pkg::BIT_CYCLES - 16'h0001;
          end
        end else begin
          next_divCnt = divCnt - 16'h0001;
        end
      end
      default: next_state = TX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= TX_IDLE;
      shifter <= '1;
      bitsLeft <= 4'h0;
      divCnt <= 16'h0000;
      txd <= 1'b1;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      shifter <= next_shifter;
      bitsLeft <= next_bitsLeft;
      divCnt <= next_divCnt;
      txd <= next_txd;
      busy <= (next_state == TX_SEND);
    end
  end
endmodule : ufcm_tx

//--- logic/ufcm_rx.sv
`timescale 1ns/1ps
module ufcm_rx (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rxd,
  input wire ufcm_pkg::ufcm_frame_t frame,
  output logic charValid,
  output ufcm_pkg::ufcm_rxchar_t rxChar
);
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_BITS = 4'b0100, RX_STOP = 4'b1000
  } ufcm_rxstate_t;
  ufcm_rxstate_t state, next_state;
  logic [8:0] sreg, next_sreg;
  logic [3:0] bitsLeft, next_bitsLeft;
  logic [15:0] divCnt, next_divCnt;
  logic next_charValid;
  ufcm_pkg::ufcm_rxchar_t next_rxChar;

  always_comb begin
    logic [8:0] al;
    logic [3:0] nBits;
    nBits = 4'd5 + 4'(frame.lenCode) + 4'(frame.hasExtra);
    al = sreg >> (4'd9 - nBits);
    next_state = state;
    next_sreg = sreg;
    next_bitsLeft = bitsLeft;
    next_divCnt = (divCnt == 16'h0000) ? ufcm_pkg::BIT_CYCLES - 16'h0001 : divCnt - 16'h0001;
    next_charValid = 1'b0;
    next_rxChar = rxChar;
    case (state)
      RX_IDLE: begin
        next_divCnt = ufcm_pkg::HALF_BIT_CYCLES - 16'h0001;
        if (!rxd) begin
          next_state = RX_START;
        end
      end
      RX_START: begin
        if (divCnt == 16'h0000) begin
          // Glitch shorter than half a bit is not a start
          next_state = rxd ? RX_IDLE : RX_BITS;
          next_bitsLeft = nBits;
        end
      end
      RX_BITS: begin
        if (divCnt == 16'h0000) begin
          next_sreg = {rxd, sreg[8:1]};
          next_bitsLeft = bitsLeft - 4'h1;
          if (bitsLeft == 4'h1) begin
            next_state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (divCnt == 16'h0000) begin
          next_rxChar.data = al[7:0] & (8'hFF >> (2'h3 - frame.lenCode));
          next_rxChar.extra = frame.hasExtra & al[5 + int'(frame.lenCode)];
          next_rxChar.frameErr = !rxd;
          next_charValid = 1'b1;
          next_state = RX_IDLE;
        end
      end
      default: next_state = RX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= RX_IDLE;
      sreg <= '0;
      bitsLeft <= 4'h0;
      divCnt <= 16'h0000;
      charValid <= 1'b0;
      rxChar <= '0;
    end else begin
      state <= next_state;
      sreg <= next_sreg;
      bitsLeft <= next_bitsLeft;
      divCnt <= next_divCnt;
      charValid <= next_charValid;
      rxChar <= next_rxChar;
    end
  end
endmodule : ufcm_rx

//--- logic/ufcm_top.sv
// Operation
// - Receiver RTS mode drops RTS when FIFO fills
// - CTS enable blocks transmit while CTS negated
// - Transmitter RTS mode drops RTS one bit after empty
// - Set command sets port bits, pins go low
// - Clear command clears port bits, pins go high
// - Enabled input change raises event, level reported
// - FIFO full pin follows full, clears on read
// - Parity mode both ones selects multi-drop
// - Multi-drop frame: start, data, flag, stop
// - Flag zero means data, one means address
// - Transmit flag captured from mode bit at load
// - Receiver off: keep address characters, drop data
// - Receiver on: flag shown in parity error bit
// - FIFO full only with all three slots used
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module ufcm_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rxd,
  output logic txd,
  input wire logic clearToSend_n,
  input wire logic [3:0] inputPins,
  output logic [7:0] outputPort_n,
  output logic fifoFullFlag,
  output logic receiverReadyFlag,
  output logic irq
);
  // ****************************************
  // State
  // ****************************************
  logic dataPhase, next_dataPhase;
  logic dpWrite, next_dpWrite;
  logic dpMapped, next_dpMapped;
  logic [3:0] dpIdx, next_dpIdx;
  logic next_hreadyout;
  logic [31:0] next_hrdata;
  logic [7:0] modeRegOne, next_modeRegOne;
  logic [7:0] modeRegTwo, next_modeRegTwo;
  logic [7:0] control, next_control;
  logic [3:0] intMask, next_intMask;
  logic [3:0] intStatus, next_intStatus;
  logic [7:0] outputPortReg, next_outputPortReg;
  logic [3:0] inputDelta, next_inputDelta;
  logic [3:0] inputPrev;
  logic overrun, next_overrun;
  logic [7:0] transmitHoldingReg, next_transmitHoldingReg;
  logic thrExtra, next_thrExtra;
  logic thrFull, next_thrFull;
  ufcm_pkg::ufcm_rxchar_t receiveHoldingFifo [3];
  logic [1:0] fifoCount, next_fifoCount;
  logic [1:0] rdPtr, next_rdPtr;
  logic [1:0] wrPtr, next_wrPtr;
  logic [15:0] idleCnt, next_idleCnt;
  logic txEmptyPrev;
  logic push, pop, txStart, txBusy, rxValid;
  ufcm_pkg::ufcm_rxchar_t rxChar, stored;
  ufcm_pkg::ufcm_frame_t frame;
  logic multiDrop, txEmpty, doWrite, doRead;
  logic [7:0] statusReg;

  function automatic logic [1:0] nextSlot(input logic [1:0] p);
    return (p == 2'h2) ? 2'h0 : p + 2'h1;
  endfunction : nextSlot

  // ****************************************
  // Serial engines
  // ****************************************
  assign multiDrop = (modeRegOne[4:3] == ufcm_pkg::PAR_MULTIDROP);
  assign frame.lenCode = modeRegOne[1:0];
  assign frame.hasExtra = (modeRegOne[4:3] != ufcm_pkg::PAR_NONE);
  assign frame.stopTwo = modeRegTwo[ufcm_pkg::MR2_STOP_TWO];
  // Clearance is checked only at character start, so a frame in flight ends cleanly
  assign txStart = thrFull && !txBusy && control[ufcm_pkg::CTL_TX_EN] &&
                   (!modeRegTwo[ufcm_pkg::MR2_CTS_EN] || !clearToSend_n);
  assign txEmpty = !thrFull && !txBusy;

  ufcm_tx txEngine (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(txStart),
    .frame(frame),
    .word(transmitHoldingReg),
    .extra(thrExtra),
    .busy(txBusy),
    .txd(txd)
  );

  ufcm_rx rxEngine (
    .ref_clk(ref_clk),
    .rst(rst),
    .rxd(rxd),
    .frame(frame),
    .charValid(rxValid),
    .rxChar(rxChar)
  );

  // ****************************************
  // Receive FIFO admission
  // ****************************************
  always_comb begin
    stored = rxChar;
    // Multi-drop keeps the flag, parity modes keep the error
    if (!multiDrop) begin
      stored.extra = frame.hasExtra && (rxChar.extra != ((modeRegOne[4:3] == ufcm_pkg::PAR_FORCE) ?
                     modeRegOne[ufcm_pkg::MR1_PAR_SEL] :
                     ufcm_pkg::parityOf(rxChar.data, frame.lenCode,
                                        modeRegOne[ufcm_pkg::MR1_PAR_SEL])));
    end
    push = rxValid && (control[ufcm_pkg::CTL_RX_EN] || (multiDrop && rxChar.extra));
  end

  assign doWrite = dataPhase && dpWrite && dpMapped;
  assign doRead = dataPhase && !dpWrite && dpMapped;
  assign pop = doRead && (dpIdx == ufcm_pkg::IDX_DATA) && (fifoCount != 2'h0);
  assign statusReg = {1'b0,
                      (fifoCount != 2'h0) && receiveHoldingFifo[rdPtr].frameErr,
                      (fifoCount != 2'h0) && receiveHoldingFifo[rdPtr].extra,
                      overrun, txEmpty, !thrFull,
                      fifoCount == ufcm_pkg::FIFO_DEPTH,
                      fifoCount != 2'h0};

  // ****************************************
  // Bus and register next state
  // ****************************************
  always_comb begin
    logic [3:0] events;
    logic addFull;
    next_dataPhase = 1'b0;
    next_dpWrite = dpWrite;
    next_dpMapped = dpMapped;
    next_dpIdx = dpIdx;
    next_hreadyout = hreadyout;
    next_hrdata = hrdata;
    next_modeRegOne = modeRegOne;
    next_modeRegTwo = modeRegTwo;
    next_control = control;
    next_intMask = intMask;
    next_outputPortReg = outputPortReg;
    next_transmitHoldingReg = transmitHoldingReg;
    next_thrExtra = thrExtra;
    next_thrFull = thrFull && !txStart;
    next_overrun = overrun || (push && fifoCount == ufcm_pkg::FIFO_DEPTH && !pop);
    next_rdPtr = pop ? nextSlot(rdPtr) : rdPtr;
    next_wrPtr = wrPtr;
    next_fifoCount = fifoCount - 2'(pop);
    addFull = 1'b0;
    if (push && (fifoCount != ufcm_pkg::FIFO_DEPTH || pop)) begin
      next_wrPtr = nextSlot(wrPtr);
      next_fifoCount = next_fifoCount + 2'h1;
      addFull = (next_fifoCount == ufcm_pkg::FIFO_DEPTH);
    end
    next_inputDelta = inputDelta;
    if (hready && hsel && htrans[1]) begin
      next_dataPhase = 1'b1;
      next_dpWrite = hwrite;
      next_dpIdx = haddr[5:2];
      next_dpMapped = (haddr[31:6] == 26'h0) &&
                      (haddr[5:2] <= ufcm_pkg::IDX_OUTPUT_PORT || haddr[5:2] >= ufcm_pkg::IDX_SET_OUTPUT);
      next_hreadyout = 1'b0;
    end
    if (dataPhase) begin
      next_hreadyout = 1'b1;
      next_hrdata = 32'h0000_0000;
    end
    if (doRead) begin
      case (dpIdx)
        ufcm_pkg::IDX_MODE_ONE: next_hrdata[7:0] = modeRegOne;
        ufcm_pkg::IDX_MODE_TWO: next_hrdata[7:0] = modeRegTwo;
        ufcm_pkg::IDX_STATUS: next_hrdata[7:0] = statusReg;
        ufcm_pkg::IDX_DATA: next_hrdata[7:0] = receiveHoldingFifo[rdPtr].data;
        ufcm_pkg::IDX_CONTROL: next_hrdata[7:0] = control;
        ufcm_pkg::IDX_INPUT_CHANGE: begin
          next_hrdata[7:0] = {inputDelta, inputPins};
          next_inputDelta = 4'h0;
        end
        ufcm_pkg::IDX_INT_STATUS: next_hrdata[3:0] = intStatus;
        ufcm_pkg::IDX_INT_MASK: next_hrdata[3:0] = intMask;
        ufcm_pkg::IDX_OUTPUT_PORT: next_hrdata[7:0] = outputPortReg;
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
    if (doWrite) begin
      case (dpIdx)
        ufcm_pkg::IDX_MODE_ONE: next_modeRegOne = hwdata[7:0];
        ufcm_pkg::IDX_MODE_TWO: next_modeRegTwo = hwdata[7:0];
        ufcm_pkg::IDX_STATUS: next_overrun = push && fifoCount == ufcm_pkg::FIFO_DEPTH && !pop;
        ufcm_pkg::IDX_DATA: begin
          next_transmitHoldingReg = hwdata[7:0];
          // Flag follows the mode bit as it stands at load time
          next_thrExtra = (multiDrop || modeRegOne[4:3] == ufcm_pkg::PAR_FORCE) ?
                          modeRegOne[ufcm_pkg::MR1_PAR_SEL] :
                          ufcm_pkg::parityOf(hwdata[7:0], frame.lenCode,
                                             modeRegOne[ufcm_pkg::MR1_PAR_SEL]);
          next_thrFull = 1'b1;
          if (modeRegTwo[ufcm_pkg::MR2_TX_RTS]) begin
            next_outputPortReg[ufcm_pkg::RTS_PIN] = 1'b1;
          end
        end
        ufcm_pkg::IDX_CONTROL: next_control = hwdata[7:0];
        ufcm_pkg::IDX_INT_MASK: next_intMask = hwdata[3:0];
        ufcm_pkg::IDX_SET_OUTPUT: next_outputPortReg = outputPortReg | hwdata[7:0];
        ufcm_pkg::IDX_CLEAR_OUTPUT: next_outputPortReg = outputPortReg & ~hwdata[7:0];
        default: next_modeRegOne = modeRegOne;
      endcase
    end
    // Hardware drops win over a same-cycle host set so a fill is never missed
    if (addFull && modeRegOne[ufcm_pkg::MR1_RX_RTS]) begin
      next_outputPortReg[ufcm_pkg::RTS_PIN] = 1'b0;
    end
    next_idleCnt = !txEmpty ? 16'h0000 :
                   (idleCnt == ufcm_pkg::BIT_CYCLES) ? idleCnt : idleCnt + 16'h0001;
    if (modeRegTwo[ufcm_pkg::MR2_TX_RTS] && txEmpty &&
        idleCnt == ufcm_pkg::BIT_CYCLES - 16'h0001) begin
      next_outputPortReg[ufcm_pkg::RTS_PIN] = 1'b0;
    end
    // New changes win over the read that clears them
    next_inputDelta = next_inputDelta | ((inputPins ^ inputPrev) & control[7:4]);
    events = {|((inputPins ^ inputPrev) & control[7:4]), txEmpty && !txEmptyPrev, addFull, push};
    next_intStatus = intStatus;
    if (doWrite && dpIdx == ufcm_pkg::IDX_INT_STATUS) begin
      next_intStatus = intStatus & ~hwdata[3:0];
    end
    next_intStatus = next_intStatus | events;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dataPhase <= 1'b0;
      dpWrite <= 1'b0;
      dpMapped <= 1'b0;
      dpIdx <= 4'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      modeRegOne <= ufcm_pkg::REG_RESET;
      modeRegTwo <= ufcm_pkg::REG_RESET;
      control <= ufcm_pkg::REG_RESET;
      intMask <= 4'h0;
      intStatus <= 4'h0;
      outputPortReg <= ufcm_pkg::REG_RESET;
      outputPort_n <= 8'hFF;
      inputDelta <= 4'h0;
      inputPrev <= 4'h0;
      overrun <= 1'b0;
      transmitHoldingReg <= 8'h00;
      thrExtra <= 1'b0;
      thrFull <= 1'b0;
      fifoCount <= 2'h0;
      rdPtr <= 2'h0;
      wrPtr <= 2'h0;
      idleCnt <= 16'h0000;
      txEmptyPrev <= 1'b1;
      fifoFullFlag <= 1'b0;
      receiverReadyFlag <= 1'b0;
      irq <= 1'b0;
    end else begin
      dataPhase <= next_dataPhase;
      dpWrite <= next_dpWrite;
      dpMapped <= next_dpMapped;
      dpIdx <= next_dpIdx;
      hreadyout <= next_hreadyout;
      hresp <= 1'b0;
      hrdata <= next_hrdata;
      modeRegOne <= next_modeRegOne;
      modeRegTwo <= next_modeRegTwo;
      control <= next_control;
      intMask <= next_intMask;
      intStatus <= next_intStatus;
      outputPortReg <= next_outputPortReg;
      outputPort_n <= ~next_outputPortReg;
      inputDelta <= next_inputDelta;
      inputPrev <= inputPins;
      overrun <= next_overrun;
      transmitHoldingReg <= next_transmitHoldingReg;
      thrExtra <= next_thrExtra;
      thrFull <= next_thrFull;
      fifoCount <= next_fifoCount;
      rdPtr <= next_rdPtr;
      wrPtr <= next_wrPtr;
      idleCnt <= next_idleCnt;
      txEmptyPrev <= txEmpty;
      fifoFullFlag <= (next_fifoCount == ufcm_pkg::FIFO_DEPTH);
      receiverReadyFlag <= (next_fifoCount != 2'h0);
      irq <= |(next_intStatus & intMask);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push && (fifoCount != ufcm_pkg::FIFO_DEPTH || pop)) begin
      receiveHoldingFifo[wrPtr] <= stored;
    end
  end
endmodule : ufcm_top

//--- tb/ufcm_remote.sv
`timescale 1ns/1ps
module ufcm_remote (
  input wire logic ref_clk,
  input wire logic ctsIn_n,
  output logic rxd
);
  initial rxd = 1'b1;
  // Eleven-bit frame, started only once our request line is asserted
  task automatic send(input logic [7:0] d, input logic ad, input int gap);
    logic [10:0] fr;
    fr = {1'b1, ad, d, 1'b0};
    repeat (gap + 1) @(posedge ref_clk);
    while (ctsIn_n) @(posedge ref_clk);
    for (int i = 0; i < 11; i++) begin
      rxd <= fr[i];
      repeat (ufcm_pkg::BIT_CYCLES) @(posedge ref_clk);
    end
  endtask : send
endmodule : ufcm_remote

//--- tb/ufcm_top_assertions.sv
`timescale 1ns/1ps
module ufcm_top_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic txd,
  input wire logic clearToSend_n,
  input wire logic [7:0] outputPort_n,
  input wire logic fifoFullFlag,
  input wire logic receiverReadyFlag
);
  // Longest high run inside a frame is eleven bits
  localparam int IDLE_MIN = 12 * int'(ufcm_pkg::BIT_CYCLES);
  logic apWr, apRd, wrDone;
  logic [3:0] apIdx;
  logic [7:0] mr1, mr2, lastWd;
  logic [10:0] idle;
  logic [2:0] sinceRd;
  assign wrDone = apWr && hreadyout;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Shadow of bus writes
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (hready) begin
      apWr <= !rst && hsel && htrans[1] && hwrite;
      apRd <= !rst && hsel && htrans[1] && !hwrite;
      apIdx <= haddr[5:2];
    end
    if (wrDone) begin
      lastWd <= hwdata[7:0];
    end
    if (rst) begin
      mr1 <= 8'h00;
      mr2 <= 8'h00;
    end else if (wrDone && apIdx == ufcm_pkg::IDX_MODE_ONE) begin
      mr1 <= hwdata[7:0];
    end else if (wrDone && apIdx == ufcm_pkg::IDX_MODE_TWO) begin
      mr2 <= hwdata[7:0];
    end
    if (rst || !txd) begin
      idle <= 11'h000;
    end else if (idle != 11'h7FF) begin
      idle <= idle + 11'h001;
    end
    if (rst) begin
      sinceRd <= 3'h7;
    end else if (apRd && !hreadyout && apIdx == ufcm_pkg::IDX_DATA) begin
      sinceRd <= 3'h0;
    end else if (sinceRd != 3'h7) begin
      sinceRd <= sinceRd + 3'h1;
    end
  end
  chk_resp_okay: assert property (!hresp)
    else $error("hresp not OKAY");
  chk_one_wait: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("wait state count wrong");
  chk_rx_rts_drop: assert property (mr1[7] && $rose(fifoFullFlag) |-> ##[0:2] outputPort_n[0])
    else $error("request line kept on full");
  chk_full_needs_data: assert property ($rose(fifoFullFlag) |-> $past(receiverReadyFlag))
    else $error("full without stored data");
  chk_set_bits: assert property (wrDone && apIdx == ufcm_pkg::IDX_SET_OUTPUT |=> ##[0:1] (outputPort_n[7:1] & lastWd[7:1]) == 7'h00)
    else $error("set command pins not low");
  chk_clear_bits: assert property (wrDone && apIdx == ufcm_pkg::IDX_CLEAR_OUTPUT |=> ##[0:1] (outputPort_n & lastWd) == lastWd)
    else $error("clear command pins not high");
  chk_cts_block: assert property (mr2[4] && idle >= IDLE_MIN && $past(clearToSend_n) && $past(clearToSend_n, 2) |-> txd)
    else $error("sent while clear-to-send off");
  chk_tx_rts_drop: assert property (mr2[5] && idle == IDLE_MIN |-> outputPort_n[0])
    else $error("request line kept after empty");
  chk_full_fall: assert property ($fell(fifoFullFlag) |-> sinceRd < 3'h3)
    else $error("full flag fell without read");
  cov_full: cover property ($rose(fifoFullFlag));
  cov_port_set: cover property (wrDone && apIdx == ufcm_pkg::IDX_SET_OUTPUT);
  cov_cts_frame: cover property ($fell(txd) && mr2[4]);
endmodule : ufcm_top_assertions
bind ufcm_top ufcm_top_assertions chk_u (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .txd, .clearToSend_n, .outputPort_n, .fifoFullFlag,
  .receiverReadyFlag);

//--- tb/uart_flow_control_multidrop_bench.sv
`timescale 1ns/1ps
module uart_flow_control_multidrop_bench;
  logic ref_clk, rst, hsel, hwrite, txd, clearToSend_n, hreadyout, hresp;
  logic fifoFullFlag, receiverReadyFlag, irq, rxd;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [3:0] inputPins;
  logic [7:0] outputPort_n, output_port_reg, d;
  logic [7:0] a [3];
  logic [10:0] f;
  integer seed;
  int nFail, totalChecks, lows;
  ufcm_top dut_u (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rxd, .txd, .clearToSend_n, .inputPins,
    .outputPort_n, .fifoFullFlag, .receiverReadyFlag, .irq);
  ufcm_remote remote_u (.ref_clk, .ctsIn_n(outputPort_n[0]), .rxd);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ****************************************
  // Bus, compare and frame tasks
  // ****************************************
  task automatic ahb(input logic [3:0] idx, input logic w, input logic [7:0] wd,
                     output logic [31:0] r);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {26'h0, idx, 2'h0};
    hwrite <= w;
    do @(posedge ref_clk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge ref_clk); while (!hreadyout);
    r = hrdata;
  endtask : ahb
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] idx, input logic [7:0] wd);
    ahb(idx, 1'b1, wd, rd);
  endtask : wr
  task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp);
    ahb(idx, 1'b0, 8'h00, rd);
    check(rd, {24'h0, exp});
  endtask : rdchk
  task automatic grab(output logic [10:0] fr);
    do @(negedge ref_clk); while (txd);
    repeat (ufcm_pkg::HALF_BIT_CYCLES) @(negedge ref_clk);
    for (int i = 0; i < 11; i++) begin
      fr[i] = txd;
      if (i < 10) repeat (ufcm_pkg::BIT_CYCLES) @(negedge ref_clk);
    end
  endtask : grab
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  // About five times the expected run
  initial begin
    repeat (60000) @(posedge ref_clk);
    nFail++;
    report_and_stop();
  end
  initial begin
    seed = 32'h4F5E;
    {rst, hsel, hwrite, clearToSend_n, haddr, hwdata, htrans, output_port_reg} = '0;
    rst = 1'b1;
    inputPins = 4'($random(seed));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    check(outputPort_n, 32'hFF);
    rdchk(ufcm_pkg::IDX_MODE_TWO, ufcm_pkg::REG_RESET);
    wr(4'h9, 8'h5A);
    rdchk(4'h9, 8'h00);
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      wr(i[0] ? ufcm_pkg::IDX_CLEAR_OUTPUT : ufcm_pkg::IDX_SET_OUTPUT, d);
      output_port_reg = i[0] ? output_port_reg & ~d : output_port_reg | d;
      rdchk(ufcm_pkg::IDX_OUTPUT_PORT, output_port_reg);
      @(negedge ref_clk);
      check(outputPort_n, 8'(~output_port_reg));
      @(posedge ref_clk);
    end
    wr(ufcm_pkg::IDX_SET_OUTPUT, 8'h01);
    wr(ufcm_pkg::IDX_MODE_ONE, 8'h9B);
    remote_u.send(8'h3C, 1'b0, 0);
    repeat (3) @(negedge ref_clk);
    check(receiverReadyFlag, 0);
    for (int k = 0; k < 3; k++) begin
      a[k] = 8'($random(seed));
      remote_u.send(a[k], 1'b1, 40 * k);
      repeat (3) @(negedge ref_clk);
      check(fifoFullFlag, k == 2);
    end
    check(outputPort_n[0], 1);
    rdchk(ufcm_pkg::IDX_DATA, a[0]);
    @(negedge ref_clk);
    check(fifoFullFlag, 0);
    check(outputPort_n[0], 1);
    wr(ufcm_pkg::IDX_SET_OUTPUT, 8'h01);
    @(negedge ref_clk);
    check(outputPort_n[0], 0);
    rdchk(ufcm_pkg::IDX_DATA, a[1]);
    rdchk(ufcm_pkg::IDX_DATA, a[2]);
    check(irq, 0);
    wr(ufcm_pkg::IDX_INT_MASK, 8'h01);
    @(negedge ref_clk);
    check(irq, 1);
    wr(ufcm_pkg::IDX_INT_STATUS, 8'h01);
    @(negedge ref_clk);
    check(irq, 0);
    wr(ufcm_pkg::IDX_CONTROL, 8'h01);
    for (int k = 0; k < 2; k++) begin
      d = 8'($random(seed));
      remote_u.send(d, k[0], 0);
      ahb(ufcm_pkg::IDX_STATUS, 1'b0, 8'h00, rd);
      check(rd[5], k);
      rdchk(ufcm_pkg::IDX_DATA, d);
    end
    wr(ufcm_pkg::IDX_INT_MASK, 8'h08);
    wr(ufcm_pkg::IDX_CONTROL, 8'h43);
    inputPins[2] <= ~inputPins[2];
    repeat (4) @(negedge ref_clk);
    check(irq, 1);
    @(posedge ref_clk);
    rdchk(ufcm_pkg::IDX_INPUT_CHANGE, {4'h4, inputPins});
    wr(ufcm_pkg::IDX_MODE_TWO, 8'h10);
    wr(ufcm_pkg::IDX_MODE_ONE, 8'h1F);
    d = 8'($random(seed));
    fork
      grab(f);
      begin
        wr(ufcm_pkg::IDX_DATA, d);
        repeat (300) @(posedge ref_clk);
        clearToSend_n <= 1'b1;
      end
    join
    check(f, {1'b1, 1'b1, d, 1'b0});
    d = 8'($random(seed));
    wr(ufcm_pkg::IDX_DATA, d);
    wr(ufcm_pkg::IDX_MODE_ONE, 8'h1B);
    lows = 0;
    repeat (1200) begin
      @(negedge ref_clk);
      lows += int'(!txd);
    end
    check(lows, 0);
    @(posedge ref_clk);
    clearToSend_n <= 1'b0;
    grab(f);
    check(f, {1'b1, 1'b1, d, 1'b0});
    wr(ufcm_pkg::IDX_MODE_TWO, 8'h30);
    repeat (130) @(negedge ref_clk);
    check(outputPort_n[0], 1);
    d = 8'($random(seed));
    fork
      grab(f);
      begin
        wr(ufcm_pkg::IDX_DATA, d);
        @(negedge ref_clk);
        check(outputPort_n[0], 0);
      end
    join
    check(f, {1'b1, 1'b0, d, 1'b0});
    repeat (30) @(negedge ref_clk);
    check(outputPort_n[0], 0);
    repeat (110) @(negedge ref_clk);
    check(outputPort_n[0], 1);
    repeat (1000) @(negedge ref_clk);
    report_and_stop();
  end
endmodule : uart_flow_control_multidrop_bench
